//--- hw/rawsock_pkg.sv
// Purpose: shared constants for the raw socket and socketless request block
// Assumes: 8-bit local register port, 100 MHz system clock
// Notes: offsets are byte addresses; multi-byte registers are big-endian
package rawsock_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int RETRY_UNIT_US = 100;
    localparam int RETRY_UNIT_CYCLES = RETRY_UNIT_US * 1000 / CLK_PERIOD_NS;

    localparam logic [7:0] A_MODE = 8'h00;
    localparam logic [7:0] A_MODE2 = 8'h01;
    localparam logic [7:0] A_CMD = 8'h02;
    localparam logic [7:0] A_STATUS = 8'h03;
    localparam logic [7:0] A_SFLAGS = 8'h04;
    localparam logic [7:0] A_PROTO = 8'h05;
    localparam logic [7:0] A_TXLEN = 8'h06;
    localparam logic [7:0] A_DHAR = 8'h08;
    localparam logic [7:0] A_DIP = 8'h0E;
    localparam logic [7:0] A_OWN = 8'h12;
    localparam logic [7:0] A_SLCMD = 8'h20;
    localparam logic [7:0] A_SLFLAGS = 8'h21;
    localparam logic [7:0] A_SLMASK = 8'h22;
    localparam logic [7:0] A_RTR = 8'h23;
    localparam logic [7:0] A_RCR = 8'h25;
    localparam logic [7:0] A_PIP = 8'h26;
    localparam logic [7:0] A_PMAC = 8'h2A;
    localparam logic [7:0] A_SEQ = 8'h30;
    localparam logic [7:0] A_ID = 8'h32;

    localparam logic [3:0] MODE_RAW_IP = 4'h3;
    localparam logic [3:0] MODE_RAW_FRAME = 4'h4;
    localparam int MODE_FILTER_BIT = 7;
    localparam int BCAST_BLK_BIT = 0;
    localparam int MCAST_BLK_BIT = 1;
    localparam int V6_BLK_BIT = 2;

    localparam logic [7:0] CMD_OPEN = 8'h01;
    localparam logic [7:0] CMD_CLOSE = 8'h10;
    localparam logic [7:0] CMD_SEND = 8'h20;
    localparam logic [7:0] CMD_SEND_MAC = 8'h21;
    localparam logic [7:0] ST_CLOSED = 8'h00;
    localparam logic [7:0] ST_RAW_IP = 8'h32;
    localparam logic [7:0] ST_RAW_FRAME = 8'h42;
    localparam int SFLAG_TIMEOUT_BIT = 3;

    localparam logic [7:0] PROTO_ICMP = 8'h01;
    localparam logic [7:0] PROTO_TCP = 8'h06;
    localparam logic [7:0] PROTO_UDP = 8'h11;

    localparam int SL_ECHO_BIT = 0;
    localparam int SL_ARP_BIT = 1;
    localparam int SL_TIMEOUT_BIT = 2;
    localparam logic [15:0] RTR_RESET = 16'h07D0;
    localparam logic [7:0] RCR_RESET = 8'h08;

    localparam int MAC_BYTES = 6;
    localparam int TYPE_BYTES = 2;
    localparam int PAYLOAD_MIN = 46;
    localparam int PAYLOAD_MAX = 1500;
    localparam logic [15:0] LEN_HDR_BYTES = 16'h0002;
    localparam logic [15:0] IP_HDR_BYTES = 16'h0006;
    localparam logic [15:0] FRAME_MIN = 16'(2 * MAC_BYTES + TYPE_BYTES + PAYLOAD_MIN);
    localparam logic [15:0] FRAME_MAX = 16'(2 * MAC_BYTES + TYPE_BYTES + PAYLOAD_MAX);
endpackage

//--- hw/rawsock_engine.sv
// Purpose: socket 0 raw IP / raw frame modes and socketless requests
// Assumes: frame classification done upstream, one frame descriptor per pulse
// Notes: register reads answer one cycle after the read strobe
//
// Our own choices: the placing of the registers and the plain strobed port.

module rawsock_engine #(
    parameter int TICK_CYCLES = rawsock_pkg::RETRY_UNIT_CYCLES
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic RX_VALID,
    input wire logic [47:0] RX_DST_MAC,
    input wire logic [47:0] RX_SRC_MAC,
    input wire logic [31:0] RX_SRC_IP,
    input wire logic RX_IPV4,
    input wire logic RX_IPV6,
    input wire logic [7:0] RX_PROTO,
    input wire logic RX_ARP_REQ,
    input wire logic RX_ARP_REPLY,
    input wire logic RX_ECHO_REQ,
    input wire logic RX_ECHO_REPLY,
    input wire logic RX_OTHER_SOCK,
    input wire logic RX_ICMP_CLAIMED,
    input wire logic [15:0] RX_LEN,
    input wire logic [15:0] RX_FREE,
    output logic RX_STORE,
    output logic RX_DROP,
    output logic [15:0] RX_HDR_LEN,
    output logic REPLY_ARP,
    output logic REPLY_ECHO,
    output logic REQ_ARP,
    output logic REQ_ECHO,
    output logic [31:0] REQ_IP,
    output logic [15:0] REQ_SEQ,
    output logic [15:0] REQ_ID,
    output logic TX_START,
    output logic [15:0] TX_LEN,
    output logic [47:0] TX_DST_MAC,
    output logic SL_IRQ
);
    typedef enum logic [2:0] {
        E_IDLE = 3'b001,
        E_SEND = 3'b010,
        E_WAIT = 3'b100
    } eng_state_t;

    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] mode2;
        logic [7:0] cmd;
        logic [7:0] status;
        logic [7:0] sflags;
        logic [7:0] proto;
        logic [0:1][7:0] tx_len;
        logic [0:5][7:0] dhar;
        logic [0:3][7:0] dip;
        logic [0:5][7:0] own;
        logic [7:0] slcmd;
        logic [7:0] slflags;
        logic [7:0] slmask;
        logic [0:1][7:0] rtr;
        logic [7:0] retry_count_limit;
        logic [0:3][7:0] pip;
        logic [0:5][7:0] pmac;
        logic [0:1][7:0] seq;
        logic [0:1][7:0] id;
        eng_state_t state;
        logic eng_sock;
        logic kind_echo;
        logic [31:0] target;
        logic [15:0] tick_cnt;
        logic [15:0] unit_cnt;
        logic [7:0] tries;
        logic [7:0] rdata;
        logic rx_store;
        logic rx_drop;
        logic [15:0] rx_hdr_len;
        logic rep_arp;
        logic rep_echo;
        logic req_arp;
        logic req_echo;
        logic tx_start;
        logic [15:0] tx_len_out;
        logic [47:0] tx_mac;
        logic sl_irq;
    } state_t;

    state_t s;
    state_t n;
    logic rst_meta;
    logic rst_n;
    logic bcast;
    logic mcast;
    logic icmp_here;
    logic ip_take;
    logic frame_take;
    logic fits;
    logic unit_tick;
    logic reply_hit;
    logic [15:0] hdr;

    function automatic logic at(input logic [7:0] a, input logic [7:0] base, input int i);
        return a == base + 8'(i);
    endfunction

    // Status that an open command leads to
    function automatic logic [7:0] open_status(input logic [3:0] m, input logic [7:0] p);
        if (m == rawsock_pkg::MODE_RAW_IP && p != rawsock_pkg::PROTO_TCP
            && p != rawsock_pkg::PROTO_UDP)
            return rawsock_pkg::ST_RAW_IP;
        if (m == rawsock_pkg::MODE_RAW_FRAME)
            return rawsock_pkg::ST_RAW_FRAME;
        return rawsock_pkg::ST_CLOSED;
    endfunction

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    assign bcast = &RX_DST_MAC;
    assign mcast = RX_DST_MAC[40] && !bcast;
    assign icmp_here = s.status == rawsock_pkg::ST_RAW_IP && s.proto == rawsock_pkg::PROTO_ICMP;
    assign ip_take = s.status == rawsock_pkg::ST_RAW_IP && RX_IPV4 && !RX_IPV6
        && RX_PROTO == s.proto;
    assign frame_take = s.status == rawsock_pkg::ST_RAW_FRAME
        && (!s.mode[rawsock_pkg::MODE_FILTER_BIT] || bcast || mcast || RX_DST_MAC == s.own)
        && !(bcast && s.mode2[rawsock_pkg::BCAST_BLK_BIT])
        && !(mcast && s.mode2[rawsock_pkg::MCAST_BLK_BIT])
        && !(RX_IPV6 && s.mode2[rawsock_pkg::V6_BLK_BIT])
        && RX_LEN >= rawsock_pkg::FRAME_MIN && RX_LEN <= rawsock_pkg::FRAME_MAX
        && (!RX_OTHER_SOCK || RX_ARP_REQ || (RX_ECHO_REQ && !RX_ICMP_CLAIMED));
    assign hdr = ip_take ? rawsock_pkg::IP_HDR_BYTES : rawsock_pkg::LEN_HDR_BYTES;
    assign fits = ({1'b0, RX_LEN} + {1'b0, hdr}) <= {1'b0, RX_FREE};
    assign unit_tick = s.tick_cnt == 16'(TICK_CYCLES - 1);
    assign reply_hit = RX_VALID && RX_SRC_IP == s.target
        && (s.kind_echo ? RX_ECHO_REPLY : RX_ARP_REPLY);

    always_comb
    begin
        n = s;
        n.rx_store = 1'b0;
        n.rx_drop = 1'b0;
        n.req_arp = 1'b0;
        n.req_echo = 1'b0;
        n.tx_start = 1'b0;
        n.rdata = 8'h00;

        // Register writes; flag clears come first so later sets win
        if (WR)
        begin
            if (ADDR == rawsock_pkg::A_MODE)
                n.mode = WDATA;
            if (ADDR == rawsock_pkg::A_MODE2)
                n.mode2 = WDATA;
            if (ADDR == rawsock_pkg::A_CMD)
                n.cmd = WDATA;
            if (ADDR == rawsock_pkg::A_SFLAGS)
                n.sflags = s.sflags & ~WDATA;
            if (ADDR == rawsock_pkg::A_PROTO)
                n.proto = WDATA;
            if (ADDR == rawsock_pkg::A_SLCMD)
                n.slcmd = WDATA;
            if (ADDR == rawsock_pkg::A_SLFLAGS)
                n.slflags = s.slflags & ~WDATA;
            if (ADDR == rawsock_pkg::A_SLMASK)
                n.slmask = WDATA;
            if (ADDR == rawsock_pkg::A_RCR)
                n.retry_count_limit = WDATA;
            for (int i = 0; i < 2; i++)
            begin
                if (at(ADDR, rawsock_pkg::A_TXLEN, i))
                    n.tx_len[i] = WDATA;
                if (at(ADDR, rawsock_pkg::A_RTR, i))
                    n.rtr[i] = WDATA;
                if (at(ADDR, rawsock_pkg::A_SEQ, i))
                    n.seq[i] = WDATA;
                if (at(ADDR, rawsock_pkg::A_ID, i))
                    n.id[i] = WDATA;
            end
            for (int i = 0; i < 4; i++)
            begin
                if (at(ADDR, rawsock_pkg::A_DIP, i))
                    n.dip[i] = WDATA;
                if (at(ADDR, rawsock_pkg::A_PIP, i))
                    n.pip[i] = WDATA;
            end
            for (int i = 0; i < 6; i++)
            begin
                if (at(ADDR, rawsock_pkg::A_DHAR, i))
                    n.dhar[i] = WDATA;
                if (at(ADDR, rawsock_pkg::A_OWN, i))
                    n.own[i] = WDATA;
                if (at(ADDR, rawsock_pkg::A_PMAC, i))
                    n.pmac[i] = WDATA;
            end
        end

        // Register reads; unmapped addresses answer zero
        if (RD)
        begin
            if (ADDR == rawsock_pkg::A_MODE)
                n.rdata = s.mode;
            if (ADDR == rawsock_pkg::A_MODE2)
                n.rdata = s.mode2;
            if (ADDR == rawsock_pkg::A_CMD)
                n.rdata = s.cmd;
            if (ADDR == rawsock_pkg::A_STATUS)
                n.rdata = s.status;
            if (ADDR == rawsock_pkg::A_SFLAGS)
                n.rdata = s.sflags;
            if (ADDR == rawsock_pkg::A_PROTO)
                n.rdata = s.proto;
            if (ADDR == rawsock_pkg::A_SLCMD)
                n.rdata = s.slcmd;
            if (ADDR == rawsock_pkg::A_SLFLAGS)
                n.rdata = s.slflags;
            if (ADDR == rawsock_pkg::A_SLMASK)
                n.rdata = s.slmask;
            if (ADDR == rawsock_pkg::A_RCR)
                n.rdata = s.retry_count_limit;
            for (int i = 0; i < 2; i++)
            begin
                if (at(ADDR, rawsock_pkg::A_TXLEN, i))
                    n.rdata = s.tx_len[i];
                if (at(ADDR, rawsock_pkg::A_RTR, i))
                    n.rdata = s.rtr[i];
                if (at(ADDR, rawsock_pkg::A_SEQ, i))
                    n.rdata = s.seq[i];
                if (at(ADDR, rawsock_pkg::A_ID, i))
                    n.rdata = s.id[i];
            end
            for (int i = 0; i < 4; i++)
            begin
                if (at(ADDR, rawsock_pkg::A_DIP, i))
                    n.rdata = s.dip[i];
                if (at(ADDR, rawsock_pkg::A_PIP, i))
                    n.rdata = s.pip[i];
            end
            for (int i = 0; i < 6; i++)
            begin
                if (at(ADDR, rawsock_pkg::A_DHAR, i))
                    n.rdata = s.dhar[i];
                if (at(ADDR, rawsock_pkg::A_OWN, i))
                    n.rdata = s.own[i];
                if (at(ADDR, rawsock_pkg::A_PMAC, i))
                    n.rdata = s.pmac[i];
            end
        end

        // Receive path
        if (RX_VALID && (ip_take || frame_take))
        begin
            n.rx_store = fits;
            n.rx_drop = !fits;
            if (fits)
                n.rx_hdr_len = RX_LEN;
        end
        n.rep_arp = RX_VALID && RX_ARP_REQ;
        n.rep_echo = RX_VALID && RX_ECHO_REQ && !icmp_here && !RX_ICMP_CLAIMED;

        // Socket commands; a resolving send waits for a free engine
        if (s.cmd != 8'h00)
        begin
            n.cmd = 8'h00;
            if (s.cmd == rawsock_pkg::CMD_OPEN)
                n.status = open_status(s.mode[3:0], s.proto);
            else if (s.cmd == rawsock_pkg::CMD_CLOSE)
                n.status = rawsock_pkg::ST_CLOSED;
            else if ((s.cmd == rawsock_pkg::CMD_SEND || s.cmd == rawsock_pkg::CMD_SEND_MAC)
                && s.status == rawsock_pkg::ST_RAW_FRAME)
            begin
                n.tx_start = 1'b1;
                n.tx_len_out = (s.tx_len < rawsock_pkg::FRAME_MIN) ? rawsock_pkg::FRAME_MIN
                    : s.tx_len;
            end
            else if (s.cmd == rawsock_pkg::CMD_SEND_MAC && s.status == rawsock_pkg::ST_RAW_IP)
            begin
                n.tx_start = 1'b1;
                n.tx_len_out = s.tx_len;
                n.tx_mac = s.dhar;
            end
            else if (s.cmd == rawsock_pkg::CMD_SEND && s.status == rawsock_pkg::ST_RAW_IP)
            begin
                if (s.state == E_IDLE && s.slcmd == 8'h00)
                begin
                    n.state = E_SEND;
                    n.eng_sock = 1'b1;
                    n.kind_echo = 1'b0;
                    n.target = s.dip;
                    n.tries = 8'h00;
                end
                else
                    n.cmd = s.cmd;
            end
        end

        // Request engine shared by socketless commands and socket resolution
        unique case (s.state)
            E_IDLE:
            begin
                if (s.slcmd != 8'h00)
                begin
                    n.state = E_SEND;
                    n.eng_sock = 1'b0;
                    n.kind_echo = !s.slcmd[rawsock_pkg::SL_ARP_BIT];
                    n.target = s.pip;
                    n.tries = 8'h00;
                end
            end
            E_SEND:
            begin
                n.req_arp = !s.kind_echo;
                n.req_echo = s.kind_echo;
                n.unit_cnt = s.rtr;
                n.tick_cnt = 16'h0000;
                n.state = E_WAIT;
            end
            E_WAIT:
            begin
                if (reply_hit)
                begin
                    n.state = E_IDLE;
                    if (s.eng_sock)
                    begin
                        n.tx_start = 1'b1;
                        n.tx_len_out = s.tx_len;
                        n.tx_mac = RX_SRC_MAC;
                    end
                    else
                    begin
                        n.slflags[s.kind_echo ? rawsock_pkg::SL_ECHO_BIT
                            : rawsock_pkg::SL_ARP_BIT] = 1'b1;
                        n.pmac = RX_SRC_MAC;
                        n.slcmd = 8'h00;
                    end
                end
                else if (unit_tick)
                begin
                    n.tick_cnt = 16'h0000;
                    if (s.unit_cnt > 16'h0001)
                        n.unit_cnt = s.unit_cnt - 16'h0001;
                    else if (s.tries < s.retry_count_limit)
                    begin
                        n.tries = s.tries + 8'h01;
                        n.state = E_SEND;
                    end
                    else
                    begin
                        n.state = E_IDLE;
                        if (s.eng_sock)
                            n.sflags[rawsock_pkg::SFLAG_TIMEOUT_BIT] = 1'b1;
                        else
                        begin
                            n.slflags[rawsock_pkg::SL_TIMEOUT_BIT] = 1'b1;
                            n.slcmd = 8'h00;
                        end
                    end
                end
                else
                    n.tick_cnt = s.tick_cnt + 16'h0001;
            end
            default:
                n.state = E_IDLE;
        endcase

        n.sl_irq = |(n.slflags & n.slmask);
    end

    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
            s.state <= E_IDLE;
            s.rtr <= rawsock_pkg::RTR_RESET;
            s.retry_count_limit <= rawsock_pkg::RCR_RESET;
        end
        else
            s <= n;
    end

    assign RDATA = s.rdata;
    assign RX_STORE = s.rx_store;
    assign RX_DROP = s.rx_drop;
    assign RX_HDR_LEN = s.rx_hdr_len;
    assign REPLY_ARP = s.rep_arp;
    assign REPLY_ECHO = s.rep_echo;
    assign REQ_ARP = s.req_arp;
    assign REQ_ECHO = s.req_echo;
    assign REQ_IP = s.target;
    assign REQ_SEQ = s.seq;
    assign REQ_ID = s.id;
    assign TX_START = s.tx_start;
    assign TX_LEN = s.tx_len_out;
    assign TX_DST_MAC = s.tx_mac;
    assign SL_IRQ = s.sl_irq;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!rst_n);

    AST_TCP_UDP_REFUSED: assert property (
        s.cmd == rawsock_pkg::CMD_OPEN && s.mode[3:0] == rawsock_pkg::MODE_RAW_IP
        && (s.proto == rawsock_pkg::PROTO_TCP || s.proto == rawsock_pkg::PROTO_UDP)
        |=> s.status == rawsock_pkg::ST_CLOSED)
        else $error("raw IP opened for TCP or UDP");
    AST_RAW_IP_OPENS: assert property (
        s.cmd == rawsock_pkg::CMD_OPEN && s.mode[3:0] == rawsock_pkg::MODE_RAW_IP
        && s.proto == rawsock_pkg::PROTO_ICMP |=> s.status == rawsock_pkg::ST_RAW_IP)
        else $error("raw IP open not reported");
    AST_CMD_CLEARS: assert property (
        s.cmd == rawsock_pkg::CMD_OPEN && !(WR && ADDR == rawsock_pkg::A_CMD)
        |=> s.cmd == 8'h00)
        else $error("open command not cleared");
    AST_ICMP_NO_REPLY: assert property (
        RX_VALID && RX_ECHO_REQ && icmp_here |=> !REPLY_ECHO)
        else $error("echo reply while ICMP socket open");
    AST_DROP_BIG: assert property (
        RX_VALID && ip_take && {1'b0, RX_LEN} + {1'b0, rawsock_pkg::IP_HDR_BYTES} > {1'b0, RX_FREE}
        |=> RX_DROP && !RX_STORE)
        else $error("oversized packet not dropped");
    AST_FILTER: assert property (
        RX_VALID && s.status == rawsock_pkg::ST_RAW_FRAME && s.mode[rawsock_pkg::MODE_FILTER_BIT]
        && !bcast && !mcast && RX_DST_MAC != s.own |=> !RX_STORE)
        else $error("filtered frame stored");
    AST_BCAST_BLOCK: assert property (
        RX_VALID && bcast && s.mode2[rawsock_pkg::BCAST_BLK_BIT] |=> !RX_STORE && !RX_DROP)
        else $error("blocked broadcast taken");
    AST_ARP_REPLY: assert property (
        RX_VALID && RX_ARP_REQ |=> REPLY_ARP)
        else $error("no automatic address reply");
    AST_PAD: assert property (
        TX_START && $past(s.status) == rawsock_pkg::ST_RAW_FRAME |-> TX_LEN >= 16'h003C)
        else $error("short frame not padded");
    AST_REQ_START: assert property (
        s.state == E_IDLE && s.slcmd != 8'h00 |=> ##1 REQ_ARP || REQ_ECHO)
        else $error("socketless request not sent");
    AST_SL_REPLY: assert property (
        s.state == E_WAIT && !s.eng_sock && !s.kind_echo && reply_hit
        |=> s.slflags[rawsock_pkg::SL_ARP_BIT] && s.slcmd == 8'h00
        && s.pmac == $past(RX_SRC_MAC))
        else $error("address reply not recorded");
    AST_SOCK_TIMEOUT_OPEN: assert property (
        $rose(s.sflags[rawsock_pkg::SFLAG_TIMEOUT_BIT]) |-> s.status == rawsock_pkg::ST_RAW_IP)
        else $error("socket closed on timeout");
endmodule

//--- test/net_peer.sv
// Purpose: remote peer answering address and echo requests
// Assumes: one request outstanding at a time
// Notes: a quiet peer never answers, for timeouts
module net_peer (
    input wire logic CLK,
    input wire logic answer,
    input wire logic req_arp,
    input wire logic req_echo,
    input wire logic [31:0] req_ip,
    output logic valid,
    output logic arp_reply,
    output logic echo_reply,
    output logic [31:0] src_ip
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cnt = 2'h0;
    logic arp = 1'b0;
    logic [31:0] ip = 32'h0;
    initial valid = 1'b0;
    // Idle line shows the inverse, never a stale match
    assign src_ip = valid ? ip : ~ip;
    assign arp_reply = valid & arp;
    assign echo_reply = valid & ~arp;
    always @(posedge CLK)
    begin
        valid <= (cnt == 2'h1);
        if (cnt != 2'h0)
            cnt <= cnt - 2'h1;
        else if (answer && (req_arp || req_echo))
        begin
            cnt <= 2'h3;
            arp <= req_arp;
            ip <= req_ip;
        end
    end
endmodule

//--- test/tb_top.sv
// Purpose: self-checking bench for the raw socket engine
// Assumes: retry tick shortened to 4 cycles
// Notes: peer answers unless answer is low
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic tv = 1'b0;
    logic v6 = 1'b0;
    logic echo_req = 1'b1;
    logic answer = 1'b1;
    logic [7:0] proto = 8'h01;
    logic [15:0] len = 16'h0000;
    logic [15:0] free = 16'h0000;
    logic [7:0] rdata;
    logic pv, parp, pecho, store, drop, rarp, recho, qarp, qecho, tx_start, irq;
    logic [31:0] pip, qip;
    logic [15:0] hdr_len, tx_len, qseq, qid;
    logic [47:0] txmac;
    logic [47:0] dmac = 48'h000000000000;
    logic arp_req = 1'b0;
    logic [3:0] sd;
    int err_count = 0;
    int checked = 0;
    always #5 clk = ~clk;
    rawsock_engine #(.TICK_CYCLES(4)) DUT (.CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .RX_VALID(tv | pv), .RX_DST_MAC(dmac),
        .RX_SRC_MAC(48'h0A0B0C0D0E0F), .RX_SRC_IP(pip), .RX_IPV4(~v6), .RX_IPV6(v6),
        .RX_PROTO(proto), .RX_ARP_REQ(arp_req), .RX_ARP_REPLY(parp), .RX_ECHO_REQ(echo_req),
        .RX_ECHO_REPLY(pecho), .RX_OTHER_SOCK(1'b0), .RX_ICMP_CLAIMED(1'b0), .RX_LEN(len),
        .RX_FREE(free), .RX_STORE(store), .RX_DROP(drop), .RX_HDR_LEN(hdr_len),
        .REPLY_ARP(rarp), .REPLY_ECHO(recho), .REQ_ARP(qarp), .REQ_ECHO(qecho), .REQ_IP(qip),
        .REQ_SEQ(qseq), .REQ_ID(qid), .TX_START(tx_start), .TX_LEN(tx_len), .TX_DST_MAC(txmac),
        .SL_IRQ(irq));
    net_peer peer (.CLK(clk), .answer(answer), .req_arp(qarp), .req_echo(qecho),
        .req_ip(qip), .valid(pv), .arp_reply(parp), .echo_reply(pecho), .src_ip(pip));
    task automatic give_verdict();
        if (err_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    // host polls until the command register reads zero
    task automatic cmd(input logic [7:0] a, input logic [7:0] d);
        wr8(a, d);
        for (int i = 0; i < 100; i++)
        begin
            @(posedge clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1 if (rdata === 8'h00)
                return;
        end
        err_count++;
        give_verdict();
    endtask
    // Broadcast destination doubles as an address request
    task automatic rx(input logic [15:0] l, input logic [15:0] f, input logic [47:0] d);
        @(posedge clk);
        tv <= 1'b1;
        len <= l;
        free <= f;
        dmac <= d;
        arp_req <= &d;
        @(posedge clk);
        tv <= 1'b0;
        arp_req <= 1'b0;
        #1 sd = {store, drop, recho, rarp};
        @(posedge clk);
        #1 sd = sd | {store, drop, recho, rarp};
    endtask
    task automatic wait_tx();
        for (int i = 0; i < 20 && tx_start !== 1'b1; i++)
            @(posedge clk) #1;
        chk(tx_start, 1'b1);
    endtask
    task automatic t_raw_ip();
        logic [7:0] pr[3] = '{8'h06, 8'h11, 8'h01};
        logic [7:0] st[3] = '{8'h00, 8'h00, 8'h32};
        for (int i = 0; i < 3; i++)
        begin
            wr8(8'h05, pr[i]);
            wr8(8'h00, 8'h03);
            cmd(8'h02, 8'h01);
            rchk(8'h03, st[i]);
        end
        rx(16'h0010, 16'h0016, 48'h000000000000);
        chk(sd, 4'b1000);
        chk(hdr_len, 16'h0010);
        rx(16'h0010, 16'h0015, 48'h000000000000);
        chk(sd, 4'b0100);
        v6 <= 1'b1;
        rx(16'h0010, 16'h0100, 48'h000000000000);
        chk(sd, 4'b0000);
        v6 <= 1'b0;
        cmd(8'h02, 8'h20);
        wait_tx();
        chk(txmac, 48'h0A0B0C0D0E0F);
        wr8(8'h0D, 8'h5A);
        wr8(8'h02, 8'h21);
        wait_tx();
        chk(txmac, 48'h00000000005A);
        cmd(8'h02, 8'h10);
    endtask
    task automatic t_raw_frame();
        wr8(8'h00, 8'h84);
        wr8(8'h01, 8'h01);
        cmd(8'h02, 8'h01);
        rchk(8'h03, 8'h42);
        rx(16'h003C, 16'h0100, 48'h000000000000);
        chk(sd, 4'b1010);
        chk(hdr_len, 16'h003C);
        rx(16'h003C, 16'h0100, 48'h020000000001);
        chk(sd, 4'b0010);
        rx(16'h003C, 16'h0100, 48'hFFFFFFFFFFFF);
        chk(sd, 4'b0011);
        wr8(8'h06, 8'h00);
        wr8(8'h07, 8'h0A);
        wr8(8'h02, 8'h20);
        wait_tx();
        chk(tx_len, 16'h003C);
        cmd(8'h02, 8'h10);
    endtask
    task automatic t_socketless();
        wr8(8'h26, 8'hC0);
        wr8(8'h29, 8'h64);
        wr8(8'h22, 8'h07);
        wr8(8'h31, 8'h2B);
        wr8(8'h32, 8'h01);
        for (int c = 2; c > 0; c--)
        begin
            cmd(8'h20, 8'(c));
            rchk(8'h21, 8'(c));
            chk(irq, 1'b1);
            for (int i = 0; i < 6; i++)
                rchk(8'(8'h2A + i), 8'(48'h0A0B0C0D0E0F >> (40 - 8 * i)));
            wr8(8'h21, 8'(c));
            rchk(8'h21, 8'h00);
        end
        answer <= 1'b0;
        wr8(8'h23, 8'h00);
        wr8(8'h24, 8'h01);
        wr8(8'h25, 8'h01);
        cmd(8'h20, 8'h02);
        rchk(8'h21, 8'h04);
        chk({qseq, qid}, 32'h002B0100);
        chk(qip, 32'hC0000064);
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rchk(8'h23, 8'h07);
        rchk(8'h25, 8'h08);
        rchk(8'h40, 8'h00);
        t_raw_ip();
        t_raw_frame();
        t_socketless();
        give_verdict();
    end
endmodule
